// ==== logic/mdc_pkg.sv ====
package mdc_pkg;

  // ==========================================================
  // sizes
  localparam int NUM_CH     = 8;
  localparam int EXT_CH     = 4;
  localparam int PERIPH_SRC = 18;
  localparam int CNT_W      = 24;
  localparam int ADDR_W     = 32;

  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [7:0] OFS_SRC   = 8'h00;  // per channel, plus ch * 0x10
  localparam logic [7:0] OFS_DST   = 8'h04;
  localparam logic [7:0] OFS_CNT   = 8'h08;
  localparam logic [7:0] OFS_CTL   = 8'h0c;
  localparam logic [7:0] OFS_OP    = 8'h80;
  localparam logic [7:0] OFS_STAT  = 8'h84;
  localparam logic [7:0] OFS_MASK  = 8'h88;
  localparam logic [7:0] OFS_STATE = 8'h8c;
  localparam int         OP_EN_BIT = 0;
  localparam int         OP_RR_BIT = 1;
  localparam int         STAT_END  = 8;      // end flags sit above half flags

  // ==========================================================
  // peripheral request sources
  localparam int SRC_SERIAL_FIFO = 0;        // 8 sources
  localparam int SRC_I2C         = 8;        // 2 sources
  localparam int SRC_ADC         = 10;       // 1 source
  localparam int SRC_MFT         = 11;       // 5 sources
  localparam int SRC_CMT         = 16;       // 2 sources

  // ==========================================================
  // field encodings
  localparam logic [1:0] TRIG_AUTO   = 2'h0;
  localparam logic [1:0] TRIG_EXT    = 2'h1;
  localparam logic [1:0] TRIG_PERIPH = 2'h2;
  localparam logic [1:0] SZ_BYTE     = 2'h0;
  localparam logic [1:0] SZ_WORD     = 2'h1;
  localparam logic [1:0] SZ_LONG     = 2'h2;
  localparam logic [1:0] SZ_16B      = 2'h3;
  localparam logic [1:0] DET_LOW     = 2'h0;
  localparam logic [1:0] DET_HIGH    = 2'h1;
  localparam logic [1:0] DET_RISE    = 2'h2;
  localparam logic [1:0] DET_FALL    = 2'h3;
  localparam logic [1:0] LAST_BEAT   = 2'h3;
  localparam logic [3:0] PIN_RESET   = 4'hf; // pins idle high with polarity 0

  // ==========================================================
  // types
  typedef struct packed {
    logic       done;
    logic [9:0] rsv;
    logic [4:0] psel;
    logic       end_pol;
    logic       ack_pol;
    logic [1:0] detect;
    logic       ie_end;
    logic       ie_half;
    logic       single;
    logic       burst;
    logic [1:0] trig;
    logic [1:0] size;
    logic       dinc;
    logic       sinc;
    logic       rsv0;
    logic       en;
  } mdc_ctl_type;

  typedef struct packed {
    logic              req;
    logic              we;
    logic [1:0]        size;
    logic [ADDR_W-1:0] addr;
    logic [31:0]       wdata;
  } mdc_bus_type;

  typedef enum logic [2:0] {ST_IDLE, ST_REQBUS, ST_READ, ST_WRITE, ST_NEXT} mdc_state_type;

  // bytes moved by one unit
  function automatic logic [31:0] mdc_unit_bytes(input logic [1:0] size);
    case (size)
      SZ_BYTE: mdc_unit_bytes = 32'h1;
      SZ_WORD: mdc_unit_bytes = 32'h2;
      SZ_LONG: mdc_unit_bytes = 32'h4;
      default: mdc_unit_bytes = 32'h10;
    endcase
  endfunction : mdc_unit_bytes

endpackage : mdc_pkg

// ==== logic/mdc_arbiter.sv ====
module mdc_arbiter #(
  parameter int NUM   = 8,
  parameter int IDX_W = 3
) (
  // requests
  input  wire logic [NUM-1:0]   req_in,
  input  wire logic             rr_in,
  input  wire logic [IDX_W-1:0] last_in,
  // grant
  output logic                  valid_out,
  output logic [IDX_W-1:0]      idx_out
);

  // ==========================================================
  // search from start, lowest offset wins
  function automatic logic [IDX_W-1:0] pick(input logic [NUM-1:0] req,
                                            input logic [IDX_W-1:0] start);
    logic found;
    int   j;
    found = 1'b0;
    pick  = '0;
    for (int k = 0; k < NUM; k++) begin
      j = (int'(start) + k) % NUM;
      if (!found && req[j]) begin
        pick  = IDX_W'(j);
        found = 1'b1;
      end
    end
  endfunction : pick

  // fixed order starts at channel zero, rotation after the last served
  always_comb begin
    valid_out = |req_in;
    idx_out   = pick(req_in, rr_in ? IDX_W'(last_in + 1'b1) : '0);
  end

endmodule : mdc_arbiter

// ==== logic/mdc_controller.sv ====
// How it works
// - eight channels, each with own source, destination, count and control
// - only channels zero to three honour the external request pins
// - units of 1, 2, 4 and 16 bytes; 16 bytes is four longwords
// - 24-bit count per channel; zero means 16,777,216 units
// - dual mode reads then writes; single mode one read per beat plus acknowledge
// - trigger by auto request, external pin or on-chip peripheral
// - peripheral selector: 8 serial fifo, 2 i2c, 1 adc, 5 timer, 2 cmt
// - auto request starts once channel and global enable are set
// - per channel cycle-stealing or burst; burst keeps the bus to the end
// - cycle stealing releases the bus after each unit, then re-arbitrates
// - fixed or round-robin channel priority, chosen by software
// - highest ranked requesting channel is granted first
// - a channel runs until its count ends, then stops and flags done
// - interrupt at half and at full count when enabled
// - external request detected by low, high, rising or falling edge
// - acknowledge and end pin polarity set per channel
module mdc_controller (
  // clock and reset
  input  wire logic                          sys_clk_in,
  input  wire logic                          rst_in,
  // register port
  input  wire logic [7:0]                    reg_addr_in,
  input  wire logic [31:0]                   reg_wdata_in,
  input  wire logic                          reg_wr_in,
  input  wire logic                          reg_rd_in,
  output logic      [31:0]                   reg_rdata_out,
  // bus mastership
  output logic                               bus_req_out,
  input  wire logic                          bus_grant_in,
  // memory access
  output mdc_pkg::mdc_bus_type               mem_out,
  input  wire logic [31:0]                   mem_rdata_in,
  input  wire logic                          mem_ack_in,
  // external device pins
  input  wire logic [mdc_pkg::EXT_CH-1:0]    transfer_request_in,
  output logic      [mdc_pkg::EXT_CH-1:0]    request_acknowledge_out,
  output logic      [mdc_pkg::EXT_CH-1:0]    transfer_end_out,
  // peripheral requests
  input  wire logic [mdc_pkg::PERIPH_SRC-1:0] periph_req_in,
  // interrupt
  output logic                               irq_out
);
  import mdc_pkg::*;

  // ==========================================================
  // state
  typedef struct packed {
    mdc_state_type                   st;
    logic [NUM_CH-1:0][ADDR_W-1:0]   src;
    logic [NUM_CH-1:0][ADDR_W-1:0]   dst;
    logic [NUM_CH-1:0][CNT_W-1:0]    cnt;
    logic [NUM_CH-1:0][CNT_W-1:0]    init;
    mdc_ctl_type [NUM_CH-1:0]        ctl;
    logic                            op_en;
    logic                            op_rr;
    logic [2*NUM_CH-1:0]             stat;
    logic [2*NUM_CH-1:0]             mask;
    logic [NUM_CH-1:0]               ext_pend;
    logic [NUM_CH-1:0]               per_pend;
    logic [EXT_CH-1:0]               ext_prev;
    logic [2:0]                      cur;
    logic [2:0]                      last;
    logic [1:0]                      beat;
    logic                            bus_req;
    logic                            irq;
    mdc_bus_type                     mem;
    logic [EXT_CH-1:0]               ack_pin;
    logic [EXT_CH-1:0]               end_pin;
    logic [31:0]                     rdata;
  } mdc_regs_type;

  mdc_regs_type        r;
  mdc_regs_type        n;
  logic [NUM_CH-1:0]   req_vec;
  logic [NUM_CH-1:0]   ext_sel;
  logic                arb_valid;
  logic [2:0]          arb_idx;
  logic                is_ch;
  logic [2:0]          reg_ch;
  logic [7:0]          reg_ofs;
  mdc_ctl_type         cur_ctl;
  logic [CNT_W-1:0]    cur_cnt;
  logic [CNT_W:0]      half_tot;
  logic                end_pulse;
  logic [NUM_CH-1:0]   end_vec;

  // ==========================================================
  // register port decode
  assign is_ch   = ~reg_addr_in[7];
  assign reg_ch  = reg_addr_in[6:4];
  assign reg_ofs = {4'h0, reg_addr_in[3:0]};
  assign cur_ctl = r.ctl[r.cur];
  assign cur_cnt = r.cnt[r.cur];

  // bus access word
  function automatic mdc_bus_type access(input logic we, input logic [ADDR_W-1:0] addr,
                                         input logic [1:0] size, input logic [31:0] wdata);
    access.req   = 1'b1;
    access.we    = we;
    access.size  = (size == SZ_16B) ? SZ_LONG : size;
    access.addr  = addr;
    access.wdata = wdata;
  endfunction : access

  // address of a longword beat inside a unit
  function automatic logic [ADDR_W-1:0] beat_addr(input logic [ADDR_W-1:0] base,
                                                  input logic [1:0] beat);
    beat_addr = base + {28'h0, beat, 2'b00};
  endfunction : beat_addr

  // ==========================================================
  // per channel request qualification
  always_comb begin
    req_vec = '0;
    ext_sel = '0;
    for (int i = 0; i < NUM_CH; i++) begin
      ext_sel[i] = (r.ctl[i].trig == TRIG_EXT);
      if (r.op_en && r.ctl[i].en && !r.ctl[i].done) begin
        case (r.ctl[i].trig)
          TRIG_AUTO: req_vec[i] = 1'b1;
          TRIG_EXT: begin
            if (i < EXT_CH) begin
              case (r.ctl[i].detect)
                DET_LOW:  req_vec[i] = ~transfer_request_in[i % EXT_CH];
                DET_HIGH: req_vec[i] = transfer_request_in[i % EXT_CH];
                default:  req_vec[i] = r.ext_pend[i];
              endcase
            end
          end
          TRIG_PERIPH: req_vec[i] = r.per_pend[i];
          default: req_vec[i] = 1'b0;
        endcase
      end
    end
  end

  // channel priority
  mdc_arbiter #(
    .NUM   (NUM_CH),
    .IDX_W (3)
  ) u_arb (
    .req_in    (req_vec),
    .rr_in     (r.op_rr),
    .last_in   (r.last),
    .valid_out (arb_valid),
    .idx_out   (arb_idx)
  );

  // ==========================================================
  // next state
  always_comb begin
    n          = r;
    n.rdata    = '0;
    end_pulse  = 1'b0;
    end_vec    = '0;
    half_tot   = {(r.init[r.cur] == '0), r.init[r.cur]};
    n.ext_prev = transfer_request_in;

    // software writes
    if (reg_wr_in) begin
      if (is_ch) begin
        case (reg_ofs)
          OFS_SRC: n.src[reg_ch] = reg_wdata_in;
          OFS_DST: n.dst[reg_ch] = reg_wdata_in;
          OFS_CNT: begin
            n.cnt[reg_ch]  = reg_wdata_in[CNT_W-1:0];
            n.init[reg_ch] = reg_wdata_in[CNT_W-1:0];
          end
          OFS_CTL: begin
            n.ctl[reg_ch]      = mdc_ctl_type'(reg_wdata_in);
            n.ctl[reg_ch].done = 1'b0;
          end
          default: ;
        endcase
      end else begin
        case (reg_addr_in)
          OFS_OP: begin
            n.op_en = reg_wdata_in[OP_EN_BIT];
            n.op_rr = reg_wdata_in[OP_RR_BIT];
          end
          OFS_MASK: n.mask = reg_wdata_in[2*NUM_CH-1:0];
          default: ;
        endcase
      end
    end

    // software reads, status clears on read
    if (reg_rd_in) begin
      if (is_ch) begin
        case (reg_ofs)
          OFS_SRC: n.rdata = r.src[reg_ch];
          OFS_DST: n.rdata = r.dst[reg_ch];
          OFS_CNT: n.rdata = {8'h0, r.cnt[reg_ch]};
          OFS_CTL: n.rdata = 32'(r.ctl[reg_ch]);
          default: n.rdata = '0;
        endcase
      end else begin
        case (reg_addr_in)
          OFS_OP:    n.rdata = {30'h0, r.op_rr, r.op_en};
          OFS_STAT: begin
            n.rdata = {16'h0, r.stat};
            n.stat  = '0;
          end
          OFS_MASK:  n.rdata = {16'h0, r.mask};
          OFS_STATE: n.rdata = {25'h0, r.cur, r.bus_req, 3'(r.st)};
          default:   n.rdata = '0;
        endcase
      end
    end

    // transfer sequencer
    case (r.st)
      ST_IDLE: begin
        if (arb_valid) begin
          n.cur     = arb_idx;
          n.beat    = '0;
          n.bus_req = 1'b1;
          n.st      = ST_REQBUS;
        end
      end
      ST_REQBUS: begin
        if (!cur_ctl.en || !r.op_en) begin
          n.bus_req = 1'b0;
          n.st      = ST_IDLE;
        end else if (bus_grant_in && req_vec[r.cur]) begin
          n.beat = '0;
          n.mem  = access(1'b0, r.src[r.cur], cur_ctl.size, 32'h0);
          n.st   = ST_READ;
        end
      end
      ST_READ: begin
        if (mem_ack_in) begin
          n.mem.req = 1'b0;
          if (!cur_ctl.single) begin
            n.mem = access(1'b1, beat_addr(r.dst[r.cur], r.beat), cur_ctl.size, mem_rdata_in);
            n.st  = ST_WRITE;
          end else if (cur_ctl.size == SZ_16B && r.beat != LAST_BEAT) begin
            n.beat = r.beat + 2'h1;
            n.mem  = access(1'b0, beat_addr(r.src[r.cur], n.beat), cur_ctl.size, 32'h0);
          end else begin
            n.st = ST_NEXT;
          end
        end
      end
      ST_WRITE: begin
        if (mem_ack_in) begin
          n.mem.req = 1'b0;
          if (cur_ctl.size == SZ_16B && r.beat != LAST_BEAT) begin
            n.beat = r.beat + 2'h1;
            n.mem  = access(1'b0, beat_addr(r.src[r.cur], n.beat), cur_ctl.size, 32'h0);
            n.st   = ST_READ;
          end else begin
            n.st = ST_NEXT;
          end
        end
      end
      ST_NEXT: begin
        n.cnt[r.cur]      = r.cnt[r.cur] - 24'h1;
        if (cur_ctl.sinc) begin
          n.src[r.cur] = r.src[r.cur] + mdc_unit_bytes(cur_ctl.size);
        end
        if (cur_ctl.dinc) begin
          n.dst[r.cur] = r.dst[r.cur] + mdc_unit_bytes(cur_ctl.size);
        end
        n.ext_pend[r.cur] = 1'b0;
        n.per_pend[r.cur] = 1'b0;
        n.last            = r.cur;
        if ((r.cnt[r.cur] - 24'h1) == half_tot[CNT_W:1] && cur_ctl.ie_half) begin
          n.stat[r.cur] = 1'b1;
        end
        if (r.cnt[r.cur] == 24'h1) begin
          n.ctl[r.cur].en   = 1'b0;
          n.ctl[r.cur].done = 1'b1;
          end_pulse         = 1'b1;
          if (cur_ctl.ie_end) begin
            n.stat[STAT_END + int'(r.cur)] = 1'b1;
          end
          n.bus_req = 1'b0;
          n.st      = ST_IDLE;
        end else if (cur_ctl.burst) begin
          n.st = ST_REQBUS;
        end else begin
          n.bus_req = 1'b0;
          n.st      = ST_IDLE;
        end
      end
      default: begin
        n.bus_req = 1'b0;
        n.mem     = '0;
        n.st      = ST_IDLE;
      end
    endcase

    // request capture after clears, so a new request is kept
    for (int i = 0; i < NUM_CH; i++) begin
      if (i < EXT_CH && r.ctl[i].trig == TRIG_EXT) begin
        if ((r.ctl[i].detect == DET_RISE &&
             transfer_request_in[i % EXT_CH] && !r.ext_prev[i % EXT_CH]) ||
            (r.ctl[i].detect == DET_FALL &&
             !transfer_request_in[i % EXT_CH] && r.ext_prev[i % EXT_CH])) begin
          n.ext_pend[i] = 1'b1;
        end
      end
      if (r.ctl[i].trig == TRIG_PERIPH && int'(r.ctl[i].psel) < PERIPH_SRC) begin
        if (periph_req_in[r.ctl[i].psel]) begin
          n.per_pend[i] = 1'b1;
        end
      end
    end

    // pins with per channel polarity
    end_vec[r.cur] = end_pulse;
    for (int i = 0; i < EXT_CH; i++) begin
      n.ack_pin[i] = (n.mem.req && n.cur == 3'(i)) ~^ n.ctl[i].ack_pol;
      n.end_pin[i] = end_vec[i] ~^ n.ctl[i].end_pol;
    end
    n.irq = |(n.stat & n.mask);
  end

  // registers
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      r         <= '0;
      r.ack_pin <= PIN_RESET;
      r.end_pin <= PIN_RESET;
    end else begin
      r <= n;
    end
  end

  // outputs
  assign reg_rdata_out           = r.rdata;
  assign bus_req_out             = r.bus_req;
  assign mem_out                 = r.mem;
  assign request_acknowledge_out = r.ack_pin;
  assign transfer_end_out        = r.end_pin;
  assign irq_out                 = r.irq;

  // ==========================================================
  // checks
  property p_ext_ignored;
    @(posedge sys_clk_in) disable iff (rst_in)
    (req_vec & ext_sel & 8'hf0) == 8'h00;
  endproperty
  a_ext_ignored: assert property (p_ext_ignored) else $error("high channel took pin request");

  property p_sixteen;
    @(posedge sys_clk_in) disable iff (rst_in)
    (r.st == ST_WRITE && mem_ack_in && cur_ctl.size == SZ_16B && r.beat != 2'h3)
      |=> (r.st == ST_READ) && (r.beat == $past(r.beat) + 2'h1);
  endproperty
  a_sixteen: assert property (p_sixteen) else $error("16-byte beat did not advance");

  property p_dual_order;
    @(posedge sys_clk_in) disable iff (rst_in)
    $rose(mem_out.req && mem_out.we) |-> ($past(r.st) == ST_READ);
  endproperty
  a_dual_order: assert property (p_dual_order) else $error("write without prior read");

  property p_auto;
    @(posedge sys_clk_in) disable iff (rst_in)
    (r.st == ST_IDLE && r.op_en && r.ctl[0].en && !r.ctl[0].done &&
     r.ctl[0].trig == TRIG_AUTO) |=> bus_req_out;
  endproperty
  a_auto: assert property (p_auto) else $error("auto request missing");

  property p_burst_hold;
    @(posedge sys_clk_in) disable iff (rst_in)
    (r.st == ST_NEXT && cur_ctl.burst && cur_cnt != 24'h1)
      |=> bus_req_out && (r.st == ST_REQBUS);
  endproperty
  a_burst_hold: assert property (p_burst_hold) else $error("burst dropped the bus");

  property p_cs_release;
    @(posedge sys_clk_in) disable iff (rst_in)
    (r.st == ST_NEXT && !cur_ctl.burst) |=> !bus_req_out ##1 (r.st != ST_READ);
  endproperty
  a_cs_release: assert property (p_cs_release) else $error("bus kept in cycle stealing");

  property p_fixed_grant;
    @(posedge sys_clk_in) disable iff (rst_in)
    (r.st == ST_IDLE && !r.op_rr && req_vec[0]) |=> (r.cur == 3'h0);
  endproperty
  a_fixed_grant: assert property (p_fixed_grant) else $error("fixed order not honoured");

  property p_end_stop;
    @(posedge sys_clk_in) disable iff (rst_in)
    (r.st == ST_NEXT && cur_cnt == 24'h1 && !reg_wr_in)
      |=> !cur_ctl.en && cur_ctl.done && (r.st == ST_IDLE);
  endproperty
  a_end_stop: assert property (p_end_stop) else $error("channel did not stop at end");

  property p_end_irq;
    @(posedge sys_clk_in) disable iff (rst_in)
    (r.st == ST_NEXT && cur_cnt == 24'h1 && cur_ctl.ie_end && r.mask[{1'b1, r.cur}])
      |=> irq_out;
  endproperty
  a_end_irq: assert property (p_end_irq) else $error("end interrupt missing");

  property p_ack_pol;
    @(posedge sys_clk_in) disable iff (rst_in)
    (mem_out.req && r.cur == 3'h0) |-> (request_acknowledge_out[0] == r.ctl[0].ack_pol);
  endproperty
  a_ack_pol: assert property (p_ack_pol) else $error("acknowledge polarity wrong");

  property p_count_step;
    @(posedge sys_clk_in) disable iff (rst_in)
    (r.st == ST_NEXT && !reg_wr_in) |=> (cur_cnt == $past(cur_cnt) - 24'h1);
  endproperty
  a_count_step: assert property (p_count_step) else $error("count did not step by one");

endmodule : mdc_controller

// ==== dv/mdc_mem_model.sv ====
module mdc_mem_model (
  // clock and reset
  input  wire logic                 sys_clk_in,
  input  wire logic                 rst_in,
  // bus side of the controller
  input  wire logic                 bus_req_in,
  input  wire mdc_pkg::mdc_bus_type mem_in,
  output logic                      bus_grant_out = 1'b0,
  output logic                      mem_ack_out = 1'b0,
  output logic      [31:0]          mem_rdata_out = 32'h0
);
  timeunit 1ns;
  timeprecision 1ns;
  import mdc_pkg::*;
  int seed = 4;
  int wait_n = 0;
  // ==========================================================
  // arbiter grants after random stalls; memory acks after random waits
  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      bus_grant_out <= 1'b0;
      mem_ack_out   <= 1'b0;
    end else begin
      if (!bus_req_in) bus_grant_out <= 1'b0;
      else if (($random(seed) & 3) == 0) bus_grant_out <= 1'b1;
      if (mem_ack_out || !mem_in.req) begin
        mem_ack_out   <= 1'b0;
        mem_rdata_out <= ~mem_rdata_out;  // released data is inverted, so it always differs from the last value
        wait_n        <= $random(seed) & 3;
      end else if (wait_n == 0) begin
        mem_ack_out   <= 1'b1;
        mem_rdata_out <= mem_in.we ? ~mem_rdata_out : mem_in.addr ^ 32'h3c5a96e1;
      end else wait_n <= wait_n - 1;
    end
  end
endmodule : mdc_mem_model

// ==== dv/mdc_controller_tb.sv ====
module mdc_controller_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import mdc_pkg::*;
  typedef struct packed {logic [2:0] ch; mdc_bus_type bus;} mdc_exp_type;
  // ==========================================================
  // signals
  logic        sys_clk_in = 0, rst_in = 1, reg_wr_in = 0, reg_rd_in = 0;
  logic [7:0]  reg_addr_in = 0;
  logic [31:0] reg_wdata_in = 0, reg_rdata_out, mem_rdata_in;
  logic        bus_req_out, bus_grant_in, mem_ack_in, irq_out, prev_req = 0;
  logic [3:0]  transfer_request_in = 0, request_acknowledge_out, transfer_end_out;
  logic [17:0] periph_req_in = 0;
  logic [15:0] exp_stat, mask;
  logic [7:0]  pol = 0, epol = 0;
  int          ends = 0, exp_ends = 0, opv = 1;
  mdc_bus_type mem_out;
  mdc_ctl_type c, lc;
  mdc_exp_type e, exp_q[$];
  int failures = 0, n_tests = 0, seed = 4, cycles = 0, drops = 0, exp_drops, lch, i, d, p;
  mdc_controller dut (.sys_clk_in, .rst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
    .reg_rd_in, .reg_rdata_out, .bus_req_out, .bus_grant_in, .mem_out, .mem_rdata_in,
    .mem_ack_in, .transfer_request_in, .request_acknowledge_out, .transfer_end_out,
    .periph_req_in, .irq_out);
  mdc_mem_model partner (.sys_clk_in, .rst_in, .bus_req_in(bus_req_out), .mem_in(mem_out),
    .bus_grant_out(bus_grant_in), .mem_ack_out(mem_ack_in), .mem_rdata_out(mem_rdata_in));
  initial forever #5 sys_clk_in = ~sys_clk_in;
  // ==========================================================
  // tasks
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : final_report
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk_in);
    reg_wr_in    <= 1'b1;
    reg_addr_in  <= a;
    reg_wdata_in <= v;
    @(posedge sys_clk_in);
    reg_wr_in    <= 1'b0;
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    @(posedge sys_clk_in);
    reg_rd_in   <= 1'b1;
    reg_addr_in <= a;
    @(posedge sys_clk_in);
    reg_rd_in   <= 1'b0;
    #1 chk(reg_rdata_out, exp);
  endtask : rdc
  // program one channel and queue the accesses it must make
  task automatic prog(input int ch, input logic [31:0] s, input logic [31:0] t, input int n);
    int u, b, nb, step;
    logic [31:0] v;
    wr(8'(ch * 16) + OFS_SRC, s);
    wr(8'(ch * 16) + OFS_DST, t);
    wr(8'(ch * 16) + OFS_CNT, 32'(n));
    nb   = (c.size == SZ_16B) ? 4 : 1;
    step = (c.size == SZ_16B) ? 16 : (1 << c.size);
    for (u = 0; u < n; u++) begin
      for (b = 0; b < nb; b++) begin
        v    = (s + 32'(b * 4)) ^ 32'h3c5a96e1;
        e.ch = ch[2:0];
        e.bus = '{req: 1'b1, we: 1'b0, size: (nb == 4) ? SZ_LONG : c.size,
                  addr: s + 32'(b * 4), wdata: 32'h0};
        exp_q.push_back(e);
        e.bus.we    = 1'b1;
        e.bus.addr  = t + 32'(b * 4);
        e.bus.wdata = v;
        if (!c.single) exp_q.push_back(e);
      end
      if (c.sinc) s = s + 32'(step);
      if (c.dinc) t = t + 32'(step);
    end
    pol[ch]   = c.ack_pol;
    epol[ch]  = c.end_pol;
    exp_ends  = exp_ends + int'(ch < 4);
    exp_stat  = exp_stat | (16'h0101 << ch);
    exp_drops = exp_drops + (c.burst ? 1 : n);
    lch = ch;
    lc  = c;
    wr(8'(ch * 16) + OFS_CTL, c);
  endtask : prog
  task automatic start;
    wr(OFS_OP, 32'h0);
    exp_stat  = 16'h0;
    exp_drops = 0;
    exp_ends  = 0;
    drops     = 0;
    mask      = 16'($random(seed));
    wr(OFS_MASK, {16'h0, mask});
  endtask : start
  task automatic go;
    int k;
    wr(OFS_OP, opv);
    ends = 0;
    for (k = 0; k < 3000 && exp_q.size() > 0; k++) @(posedge sys_clk_in);
    repeat (8) @(posedge sys_clk_in);
    #1 chk(exp_q.size(), 0);
    chk(irq_out, |(exp_stat & mask));
    chk(drops, exp_drops);
    chk(ends, exp_ends);
    rdc(OFS_STAT, {16'h0, exp_stat});
    rdc(OFS_STAT, 32'h0);
    chk(irq_out, 1'b0);
    rdc(8'(lch * 16) + OFS_CNT, 32'h0);
    rdc(8'(lch * 16) + OFS_CTL, {1'b1, lc[30:1], 1'b0});
  endtask : go
  // ==========================================================
  // monitor: every access against the queue, plus timeout
  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == 60000) begin
      failures++;
      final_report;
    end
    prev_req <= bus_req_out;
    if (prev_req && !bus_req_out) drops++;
    for (int k = 0; k < 4; k++) if (transfer_end_out[k] == epol[k]) ends++;
    if (mem_out.req && mem_ack_in) begin
      if (exp_q.size() == 0) chk(1'b1, 1'b0);
      else begin
        e = exp_q.pop_front();
        chk({mem_out.we, mem_out.size, mem_out.addr}, {e.bus.we, e.bus.size, e.bus.addr});
        if (e.bus.we) chk(mem_out.wdata, e.bus.wdata);
        if (e.ch < 4) chk(request_acknowledge_out[e.ch[1:0]], pol[e.ch]);
      end
    end
  end
  // ==========================================================
  // main sequence
  initial begin
    repeat (20) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    for (i = 0; i < 36; i++) rdc(8'(i * 4), 32'h0);
    rdc(8'hf0, 32'h0);
    chk({request_acknowledge_out, transfer_end_out, irq_out}, {PIN_RESET, PIN_RESET, 1'b0});
    // every unit size, both bus modes, random address modes
    for (i = 0; i < 8; i++) begin
      start;
      c = '0;
      {c.sinc, c.dinc, c.single, c.ack_pol, c.end_pol} = 5'($random(seed));
      {c.en, c.ie_half, c.ie_end, c.size, c.burst} = {3'h7, i[1:0], i[2]};
      prog($random(seed) & 7, $random(seed) & ~15, $random(seed) & ~15, 1 + ($random(seed) & 3));
      go;
    end
    // fixed priority: channel zero before channel three
    start;
    c.burst = 1'b0;
    prog(0, 32'h1000, 32'h2000, 2);
    prog(3, 32'h3000, 32'h4000, 2);
    go;
    // round robin: search starts after channel three, so five before two
    start;
    opv = 3;
    prog(5, 32'h9000, 32'ha000, 1);
    prog(2, 32'hb000, 32'hc000, 1);
    go;
    // external pin in each detect mode on channels zero to three
    for (d = 0; d < 4; d++) begin
      start;
      wr(OFS_OP, 32'h1);
      transfer_request_in <= {4{d == 0 || d == 3}};
      {c.trig, c.detect, c.size, c.ack_pol} = {TRIG_EXT, d[1:0], SZ_WORD, 1'($random(seed))};
      prog(d, 32'h5000, 32'h6000, 1);
      repeat (10) @(posedge sys_clk_in);
      chk(bus_req_out, 1'b0);
      transfer_request_in <= {4{!(d == 0 || d == 3)}};
      go;
      transfer_request_in <= {4{d == 0 || d == 3}};
    end
    // channel four has no pin: must stay quiet with all pins active low
    c.detect = DET_LOW;
    transfer_request_in <= 4'h0;
    wr(8'h4c, c);
    repeat (20) @(posedge sys_clk_in);
    chk(bus_req_out, 1'b0);
    wr(8'h4c, 32'h0);
    // peripheral request on a random source
    p = {$random(seed)} % PERIPH_SRC;
    start;
    wr(OFS_OP, 32'h1);
    {c.trig, c.psel} = {TRIG_PERIPH, 5'(p)};
    prog(6, 32'h7000, 32'h8000, 1);
    repeat (10) @(posedge sys_clk_in);
    chk(bus_req_out, 1'b0);
    periph_req_in[p] <= 1'b1;
    @(posedge sys_clk_in);
    periph_req_in[p] <= 1'b0;
    go;
    final_report;
  end
endmodule : mdc_controller_tb
